// ===== branch_operand_address_decoder.sv
// top of the branch and operand address decoder
`timescale 1ns/1ps
module branch_operand_address_decoder (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        step,
  input  wire logic [7:0]  branch_kind,
  input  wire logic [1:0]  fetch_bytes,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  byte2,
  input  wire logic [7:0]  byte3,
  input  wire logic        reg_jump_ext,
  input  wire logic [15:0] mem_word,
  input  wire logic [15:0] general_pair_one,
  input  wire logic [15:0] extended_accumulator_pair,
  input  wire logic [7:0]  acc_byte,
  input  wire logic [7:0]  b_reg_byte,
  input  wire logic [15:0] vector_accumulator_pair,
  input  wire logic        alt_pair_set,
  input  wire logic [2:0]  pair_select_field,
  input  wire logic [3:0]  mode_field,
  input  wire logic        use_alternate,
  input  wire logic        mem_access,
  input  wire logic        block_move,
  input  wire logic [2:0]  stack_op,
  input  wire logic [2:0]  extended_register_field,
  input  wire logic [5:0]  special_register_field,
  input  wire logic        special_is_source,
  input  wire logic [4:0]  irf_field,
  output logic      [15:0] pc_ff,
  output logic      [15:0] sp_ff,
  output logic      [15:0] pair_two_ff,
  output logic      [15:0] pair_three_ff,
  output logic      [15:0] oper_addr_ff,
  output logic      [15:0] oper_addr2_ff,
  output logic      [15:0] table_addr_ff,
  output logic      [15:0] pair_value_ff,
  output logic             mode_valid_ff,
  output logic      [7:0]  ext_sel_ff,
  output logic             spec_valid_ff,
  output logic             irf_valid_ff
);
  // ---------------------------------------------------------------
  // program counter targets
  // ---------------------------------------------------------------
  wire [15:0] next_seq = pc_ff + {14'h0000, fetch_bytes};
  wire [15:0] reg_tgt = reg_jump_ext ? extended_accumulator_pair
                                     : general_pair_one;
  wire [15:0] imm_tgt = {byte3, byte2};
  wire [15:0] short_tgt = addr_decode_pkg::SHORT_BASE
    | {5'h00, opcode[2:0], byte2};
  wire [15:0] rel6_tgt = next_seq
    + {{10{opcode[5]}}, opcode[5:0]};
  wire [15:0] rel9_tgt = next_seq
    + {{8{opcode[0]}}, byte2};
  wire [15:0] tbl_addr = addr_decode_pkg::TABLE_BASE
    + {10'h000, opcode[4:0], 1'b0};
  wire        br_seq  = branch_kind == addr_decode_pkg::BR_SEQ;
  wire        br_reg  = branch_kind == addr_decode_pkg::BR_REG;
  wire        br_imm  = branch_kind == addr_decode_pkg::BR_IMM;
  wire        br_sh   = branch_kind == addr_decode_pkg::BR_SHORT;
  wire        br_tbl  = branch_kind == addr_decode_pkg::BR_TABLE;
  wire        br_r6   = branch_kind == addr_decode_pkg::BR_REL6;
  wire        br_r9   = branch_kind == addr_decode_pkg::BR_REL9;
  wire [15:0] nxt_pc = br_reg ? reg_tgt
    : br_imm ? imm_tgt
    : br_sh  ? short_tgt
    : br_tbl ? mem_word
    : br_r6  ? rel6_tgt
    : br_r9  ? rel9_tgt
    : br_seq ? next_seq
    : pc_ff;

  // ---------------------------------------------------------------
  // operand address modes
  // ---------------------------------------------------------------
  wire       mode_inc  = mode_field == addr_decode_pkg::IND_INC2
    || mode_field == addr_decode_pkg::IND_INC3;
  wire       mode_dec  = !use_alternate
    && (mode_field == addr_decode_pkg::IND_DEC2
    || mode_field == addr_decode_pkg::IND_DEC3);
  wire       mode_dbl  = use_alternate && mode_inc;
  wire       mode_sgl  = !use_alternate && mode_inc;
  wire       use_three = mode_field[0] || mode_field[3];
  wire [15:0] base_pair = use_three ? pair_three_ff : pair_two_ff;
  wire       mode_ok = (mode_field >= addr_decode_pkg::IND_ONE
    && mode_field <= addr_decode_pkg::IND_DEC3
    && !(use_alternate && mode_field == addr_decode_pkg::IND_ONE)
    && !(use_alternate && mode_field[3:1] == 3'h3))
    || mode_field == addr_decode_pkg::IND_BYTE2
    || mode_field >= addr_decode_pkg::IND_ACC3;
  // effective address per mode
  wire [15:0] eff_addr =
      mode_field == addr_decode_pkg::IND_ONE ? general_pair_one
    : mode_field == addr_decode_pkg::IND_BYTE2
      ? pair_two_ff + {8'h00, byte2}
    : mode_field == addr_decode_pkg::IND_BYTE3
      ? pair_three_ff + {8'h00, byte2}
    : mode_field == addr_decode_pkg::IND_ACC3
      ? pair_three_ff + {8'h00, acc_byte}
    : mode_field == addr_decode_pkg::IND_BREG3
      ? pair_three_ff + {8'h00, b_reg_byte}
    : mode_field == addr_decode_pkg::IND_EXT3
      ? pair_three_ff + extended_accumulator_pair
    : base_pair;
  // pair write-back after the access
  wire [15:0] upd_pair = mode_dbl ? base_pair + addr_decode_pkg::STEP_TWO
    : mode_sgl ? base_pair + addr_decode_pkg::STEP_ONE
    : base_pair - addr_decode_pkg::STEP_ONE;
  wire        upd_en = mem_access && (mode_sgl || mode_dec || mode_dbl);
  wire        upd_three = upd_en && use_three;
  wire        upd_two = upd_en && !use_three;

  // ---------------------------------------------------------------
  // block move and stack
  // ---------------------------------------------------------------
  wire        is_push = stack_op == addr_decode_pkg::STK_PUSH;
  wire        is_pop  = stack_op == addr_decode_pkg::STK_POP;
  wire [15:0] nxt_sp = is_pop ? sp_ff + addr_decode_pkg::STEP_TWO
    : is_push ? sp_ff - addr_decode_pkg::STEP_TWO
    : sp_ff;
  wire [15:0] nxt_two = block_move
    ? pair_two_ff + addr_decode_pkg::STEP_ONE
    : upd_two ? upd_pair : pair_two_ff;
  wire [15:0] nxt_three = block_move
    ? pair_three_ff + addr_decode_pkg::STEP_ONE
    : upd_three ? upd_pair : pair_three_ff;
  wire [15:0] stk_a1 = is_pop ? sp_ff
    : sp_ff - addr_decode_pkg::STEP_ONE;
  wire [15:0] stk_a2 = is_pop ? sp_ff + addr_decode_pkg::STEP_ONE
    : sp_ff - addr_decode_pkg::STEP_TWO;
  wire        stk_any = is_pop || is_push;
  wire [15:0] nxt_a1 = stk_any ? stk_a1
    : block_move ? pair_three_ff : eff_addr;
  wire [15:0] nxt_a2 = stk_any ? stk_a2
    : block_move ? pair_two_ff
    : eff_addr + addr_decode_pkg::STEP_ONE;

  // ---------------------------------------------------------------
  // register pair and field selection
  // ---------------------------------------------------------------
  wire [15:0] pair_sp = alt_pair_set ? vector_accumulator_pair : sp_ff;
  wire [15:0] nxt_pv =
      pair_select_field == addr_decode_pkg::PAIR_SP ? pair_sp
    : pair_select_field == addr_decode_pkg::PAIR_ONE ? general_pair_one
    : pair_select_field == addr_decode_pkg::PAIR_TWO ? pair_two_ff
    : pair_select_field == addr_decode_pkg::PAIR_THR ? pair_three_ff
    : pair_select_field == addr_decode_pkg::PAIR_EXT
      ? extended_accumulator_pair : 16'h0000;
  logic [7:0] ext_oh;
  logic       spec_ok;
  logic       irf_ok;
  reg_field_decoder u_fields (
    .ext_field      (extended_register_field),
    .spec_field     (special_register_field),
    .spec_is_source (special_is_source),
    .irf_field      (irf_field),
    .ext_onehot     (ext_oh),
    .spec_valid     (spec_ok),
    .irf_valid      (irf_ok)
  );

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // pc, sp and the two auto-updated pairs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pc_ff         <= addr_decode_pkg::PC_RESET;
      sp_ff         <= addr_decode_pkg::SP_RESET;
      pair_two_ff   <= 16'h0000;
      pair_three_ff <= 16'h0000;
    end
    else if (step)
    begin
      pc_ff         <= nxt_pc;
      sp_ff         <= nxt_sp;
      pair_two_ff   <= nxt_two;
      pair_three_ff <= nxt_three;
    end
  end

  // registered decode results
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      oper_addr_ff  <= 16'h0000;
      oper_addr2_ff <= 16'h0000;
      table_addr_ff <= 16'h0000;
      pair_value_ff <= 16'h0000;
      mode_valid_ff <= 1'b0;
      ext_sel_ff    <= 8'h00;
      spec_valid_ff <= 1'b0;
      irf_valid_ff  <= 1'b0;
    end
    else if (step)
    begin
      oper_addr_ff  <= nxt_a1;
      oper_addr2_ff <= nxt_a2;
      table_addr_ff <= tbl_addr;
      pair_value_ff <= nxt_pv;
      mode_valid_ff <= mode_ok;
      ext_sel_ff    <= ext_oh;
      spec_valid_ff <= spec_ok;
      irf_valid_ff  <= irf_ok;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  pc_sequential_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && br_seq |=> pc_ff == $past(pc_ff) + {14'h0000, $past(fetch_bytes)})
    else $error("pc did not advance by fetched bytes");
  pc_reg_jump_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && br_reg && !reg_jump_ext |=> pc_ff == $past(general_pair_one))
    else $error("register jump target wrong");
  pc_imm_jump_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && br_imm |=> pc_ff == {$past(byte3), $past(byte2)})
    else $error("immediate jump target wrong");
  short_call_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && br_sh |=> pc_ff[10:0] == {$past(opcode[2:0]), $past(byte2)})
    else $error("short call target wrong");
  rel6_sign_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && br_r6 && opcode[5] |=> pc_ff != $past(next_seq)
      + {10'h000, $past(opcode[5:0])})
    else $error("short branch not sign extended");
  stack_pop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && is_pop |=> sp_ff == $past(sp_ff) + 16'h0002
      && oper_addr2_ff == oper_addr_ff + 16'h0001)
    else $error("pop stack update wrong");
  stack_push_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && is_push |=> sp_ff < $past(sp_ff) || $past(sp_ff) < 16'h0002)
    else $error("push did not lower sp");
  block_move_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && block_move && !stk_any |=> pair_two_ff == $past(pair_two_ff)
      + 16'h0001 && oper_addr_ff == $past(pair_three_ff))
    else $error("block move update wrong");
  post_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step && mem_access && mode_dec && !block_move
      && mode_field == addr_decode_pkg::IND_DEC3
    |=> pair_three_ff == $past(pair_three_ff) - 16'h0001)
    else $error("post decrement wrong");
  cov_rel9_c: cover property (@(posedge sys_clk) step && br_r9);
  cov_dbl_c: cover property (@(posedge sys_clk) step && mem_access
    && mode_dbl);
  cov_tbl_c: cover property (@(posedge sys_clk) step && br_tbl);
endmodule // branch_operand_address_decoder

// ===== addr_decode_pkg.sv
// package of constants for the branch and operand address decoder
package addr_decode_pkg;
  // branch kinds presented by the sequencer
  typedef enum logic [7:0] {
    BR_SEQ   = 8'h01,
    BR_REG   = 8'h02,
    BR_IMM   = 8'h04,
    BR_SHORT = 8'h08,
    BR_TABLE = 8'h10,
    BR_REL6  = 8'h20,
    BR_REL9  = 8'h40,
    BR_NONE  = 8'h80
  } branch_kind_t;
  // stack actions
  typedef enum logic [2:0] {
    STK_IDLE = 3'h1,
    STK_PUSH = 3'h2,
    STK_POP  = 3'h4
  } stack_op_t;
  // pair codes of the pair select field
  localparam logic [2:0] PAIR_SP   = 3'h0;
  localparam logic [2:0] PAIR_ONE  = 3'h1;
  localparam logic [2:0] PAIR_TWO  = 3'h2;
  localparam logic [2:0] PAIR_THR  = 3'h3;
  localparam logic [2:0] PAIR_EXT  = 3'h4;
  // indirect mode codes
  localparam logic [3:0] IND_ONE   = 4'h1;
  localparam logic [3:0] IND_TWO   = 4'h2;
  localparam logic [3:0] IND_THR   = 4'h3;
  localparam logic [3:0] IND_INC2  = 4'h4;
  localparam logic [3:0] IND_INC3  = 4'h5;
  localparam logic [3:0] IND_DEC2  = 4'h6;
  localparam logic [3:0] IND_DEC3  = 4'h7;
  localparam logic [3:0] IND_BYTE2 = 4'hB;
  localparam logic [3:0] IND_ACC3  = 4'hC;
  localparam logic [3:0] IND_BREG3 = 4'hD;
  localparam logic [3:0] IND_EXT3  = 4'hE;
  localparam logic [3:0] IND_BYTE3 = 4'hF;
  // address arithmetic
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  localparam logic [15:0] TABLE_BASE = 16'h0080;
  localparam logic [15:0] SHORT_BASE = 16'h0800;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // register select code width and interrupt flag code limits
  localparam int SPEC_W = 6;
  localparam logic [4:0] IRF_LAST_LOW = 5'h0C;
  localparam logic [4:0] IRF_AN_FIRST = 5'h10;
  localparam logic [4:0] IRF_STANDBY = 5'h14;
endpackage

// ===== reg_field_decoder.sv
// decoder of register, special register and interrupt flag fields
`timescale 1ns/1ps
module reg_field_decoder (
  input  wire logic [2:0] ext_field,
  input  wire logic [5:0] spec_field,
  input  wire logic       spec_is_source,
  input  wire logic [4:0] irf_field,
  output logic      [7:0] ext_onehot,
  output logic            spec_valid,
  output logic            irf_valid
);
  // extended code one-hot: ext acc high, low, then six byte regs
  assign ext_onehot = 8'h01 << ext_field;
  // destination set codes
  wire dest_ok = (spec_field <= 6'h0D && spec_field != 6'h04)
    || (spec_field >= 6'h10 && spec_field <= 6'h14)
    || spec_field == 6'h17 || spec_field == 6'h18
    || spec_field == 6'h1A || spec_field == 6'h1B
    || spec_field == 6'h28;
  // source set codes
  wire src_ok = (spec_field <= 6'h09 && spec_field != 6'h04)
    || spec_field == 6'h0B || spec_field == 6'h0D
    || spec_field == 6'h19
    || (spec_field >= 6'h20 && spec_field <= 6'h23);
  assign spec_valid = spec_is_source ? src_ok : dest_ok;
  // interrupt flag selector codes
  assign irf_valid = irf_field <= addr_decode_pkg::IRF_LAST_LOW
    || (irf_field >= addr_decode_pkg::IRF_AN_FIRST
        && irf_field <= addr_decode_pkg::IRF_STANDBY);
endmodule // reg_field_decoder

// ===== vector_memory_model.sv
// memory model answering table vector reads of the decoder
`timescale 1ns/1ps
module vector_memory_model (
  input  wire logic [15:0] table_addr,
  output logic      [15:0] mem_word
);
  // word built from the address so every vector slot differs
  assign mem_word = {~table_addr[7:0], table_addr[7:0]};
endmodule // vector_memory_model

// ===== testbench.sv
// self-checking testbench of the branch and operand address decoder
`timescale 1ns/1ps
module testbench;
  // --------------------------------------------------------------
  // stimulus tables
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  kind;
    logic [1:0]  fb;
    logic [7:0]  op;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic        rx;
    logic [15:0] pc;
  } row_t;
  typedef struct packed {
    logic [3:0]  md;
    logic [2:0]  fl;
    logic [2:0]  stk;
    logic [7:0]  b2;
    logic [15:0] a;
    logic [15:0] a2;
    logic [15:0] p2;
    logic [15:0] p3;
    logic [15:0] sp;
  } op_row_t;
  // branch rows chained from pc zero
  row_t rows [12] = '{
    '{8'h01, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0001},
    '{8'h04, 2'h3, 8'h00, 8'h34, 8'h12, 1'b0, 16'h1234},
    '{8'h20, 2'h1, 8'h20, 8'h00, 8'h00, 1'b0, 16'h1215},
    '{8'h20, 2'h1, 8'h1F, 8'h00, 8'h00, 1'b0, 16'h1235},
    '{8'h40, 2'h2, 8'h01, 8'h00, 8'h00, 1'b0, 16'h1137},
    '{8'h40, 2'h2, 8'h00, 8'hFF, 8'h00, 1'b0, 16'h1238},
    '{8'h08, 2'h2, 8'h05, 8'hAB, 8'h00, 1'b0, 16'h0DAB},
    '{8'h02, 2'h1, 8'h03, 8'h00, 8'h00, 1'b0, 16'hBEEF},
    '{8'h02, 2'h1, 8'h03, 8'h00, 8'h00, 1'b1, 16'hCAFE},
    '{8'h10, 2'h1, 8'h03, 8'h00, 8'h00, 1'b0, 16'h7986},
    '{8'h80, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 16'h7986},
    '{8'h01, 2'h3, 8'h00, 8'h00, 8'h00, 1'b0, 16'h7989}};
  // operand rows: flags are alternate, apply update, block move
  op_row_t ops [15] = '{
    '{4'h4, 3'h2, 3'h1, 8'h00, 16'h0000, 16'h0, 16'h0001, 16'h0, 16'h0},
    '{4'h7, 3'h2, 3'h1, 8'h00, 16'h0000, 16'h0, 16'h0001, 16'hFFFF, 16'h0},
    '{4'h5, 3'h6, 3'h1, 8'h00, 16'hFFFF, 16'h0, 16'h0001, 16'h0001, 16'h0},
    '{4'h6, 3'h0, 3'h1, 8'h00, 16'h0001, 16'h0, 16'h0001, 16'h0001, 16'h0},
    '{4'h0, 3'h1, 3'h1, 8'h00, 16'h0001, 16'h1, 16'h0002, 16'h0002, 16'h0},
    '{4'hB, 3'h2, 3'h1, 8'hF0, 16'h00F2, 16'h0, 16'h0002, 16'h0002, 16'h0},
    '{4'hF, 3'h2, 3'h1, 8'hFF, 16'h0101, 16'h0, 16'h0002, 16'h0002, 16'h0},
    '{4'hC, 3'h2, 3'h1, 8'h00, 16'h0082, 16'h0, 16'h0002, 16'h0002, 16'h0},
    '{4'hD, 3'h2, 3'h1, 8'h00, 16'h0101, 16'h0, 16'h0002, 16'h0002, 16'h0},
    '{4'hE, 3'h2, 3'h1, 8'h00, 16'hCB00, 16'h0, 16'h0002, 16'h0002, 16'h0},
    '{4'h1, 3'h2, 3'h1, 8'h00, 16'hBEEF, 16'h0, 16'h0002, 16'h0002, 16'h0},
    '{4'h4, 3'h6, 3'h1, 8'h00, 16'h0002, 16'h3, 16'h0004, 16'h0002, 16'h0},
    '{4'h0, 3'h0, 3'h2, 8'h00, 16'hFFFF, 16'hFFFE, 16'h4, 16'h2, 16'hFFFE},
    '{4'h0, 3'h0, 3'h4, 8'h00, 16'hFFFE, 16'hFFFF, 16'h4, 16'h2, 16'h0},
    '{4'h0, 3'h0, 3'h4, 8'h00, 16'h0000, 16'h0001, 16'h4, 16'h2, 16'h2}};
  logic [15:0] pv [6] = '{16'h0002, 16'hBEEF, 16'h0004, 16'h0002,
                          16'hCAFE, 16'h5A5A};
  localparam logic [63:0] DST_MAP = 64'h0000_0100_0D9F_3FEF;
  localparam logic [63:0] SRC_MAP = 64'h0000_000F_0200_2BEF;
  localparam logic [31:0] IRF_MAP = 32'h001F_1FFF;
  localparam logic [31:0] MODE_MAP = 32'hF83C_F8FE;
  // --------------------------------------------------------------
  // design hookup
  // --------------------------------------------------------------
  logic        sys_clk, rst_n, step, reg_jump_ext, alt_pair_set;
  logic        use_alternate, mem_access, block_move, special_is_source;
  logic [7:0]  branch_kind, opcode, byte2, byte3, acc_byte, b_reg_byte;
  logic [1:0]  fetch_bytes;
  logic [15:0] mem_word, general_pair_one, extended_accumulator_pair;
  logic [15:0] vector_accumulator_pair;
  logic [2:0]  pair_select_field, stack_op, extended_register_field;
  logic [3:0]  mode_field;
  logic [5:0]  special_register_field;
  logic [4:0]  irf_field;
  logic [15:0] pc_ff, sp_ff, pair_two_ff, pair_three_ff, oper_addr_ff;
  logic [15:0] oper_addr2_ff, table_addr_ff, pair_value_ff;
  logic        mode_valid_ff, spec_valid_ff, irf_valid_ff;
  logic [7:0]  ext_sel_ff;
  int          mismatches, total_checks, cycles;
  branch_operand_address_decoder uut (.sys_clk, .rst_n, .step,
    .branch_kind, .fetch_bytes, .opcode, .byte2, .byte3, .reg_jump_ext,
    .mem_word, .general_pair_one, .extended_accumulator_pair, .acc_byte,
    .b_reg_byte, .vector_accumulator_pair, .alt_pair_set,
    .pair_select_field, .mode_field, .use_alternate, .mem_access,
    .block_move, .stack_op, .extended_register_field,
    .special_register_field, .special_is_source, .irf_field, .pc_ff,
    .sp_ff, .pair_two_ff, .pair_three_ff, .oper_addr_ff, .oper_addr2_ff,
    .table_addr_ff, .pair_value_ff, .mode_valid_ff, .ext_sel_ff,
    .spec_valid_ff, .irf_valid_ff);
  vector_memory_model mem (.table_addr(table_addr_ff), .mem_word);
  // clock and hang guard
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one step edge, then one idle edge so outputs must stand
  task automatic tick;
    step = 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    step = 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {step, reg_jump_ext, alt_pair_set, use_alternate} = 4'h0;
    {mem_access, block_move, special_is_source} = 3'h0;
    {branch_kind, opcode, byte2, byte3} = {8'h80, 24'h0};
    {fetch_bytes, mode_field, irf_field} = 11'h0;
    {pair_select_field, extended_register_field} = 6'h0;
    {stack_op, special_register_field} = {3'h1, 6'h0};
    {acc_byte, b_reg_byte} = 16'h80FF;
    general_pair_one = 16'hBEEF;
    extended_accumulator_pair = 16'hCAFE;
    vector_accumulator_pair = 16'h5A5A;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    check("pc reset", pc_ff, 16'h0000);
    check("sp reset", sp_ff, 16'h0000);
    rst_n = 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    foreach (rows[i])
    begin
      branch_kind = rows[i].kind;
      fetch_bytes = rows[i].fb;
      opcode = rows[i].op;
      byte2 = rows[i].b2;
      byte3 = rows[i].b3;
      reg_jump_ext = rows[i].rx;
      tick();
      check("pc", pc_ff, rows[i].pc);
    end
    branch_kind = 8'h80;
    opcode = 8'h1F;
    tick();
    check("table addr", table_addr_ff, 16'h00BE);
    for (int i = 0; i < 64; i++)
    begin
      extended_register_field = 3'(i);
      special_register_field = 6'(i);
      irf_field = 5'(i);
      {use_alternate, mode_field} = 5'(i);
      special_is_source = 1'b0;
      tick();
      check("spec dst", {15'h0, spec_valid_ff}, {15'h0, DST_MAP[i]});
      if (i < 8)
        check("ext sel", {8'h00, ext_sel_ff}, 16'h0001 << i);
      if (i < 32)
        check("irf", {15'h0, irf_valid_ff}, {15'h0, IRF_MAP[i]});
      if (i < 32)
        check("mode", {15'h0, mode_valid_ff}, {15'h0, MODE_MAP[i]});
      special_is_source = 1'b1;
      tick();
      check("spec src", {15'h0, spec_valid_ff}, {15'h0, SRC_MAP[i]});
    end
    foreach (ops[i])
    begin
      mode_field = ops[i].md;
      {use_alternate, mem_access, block_move} = ops[i].fl;
      stack_op = ops[i].stk;
      byte2 = ops[i].b2;
      tick();
      check("oper addr", oper_addr_ff, ops[i].a);
      if (ops[i].fl[2] || ops[i].fl[0] || ops[i].stk != 3'h1)
        check("oper addr2", oper_addr2_ff, ops[i].a2);
      check("pair two", pair_two_ff, ops[i].p2);
      check("pair three", pair_three_ff, ops[i].p3);
      check("sp", sp_ff, ops[i].sp);
    end
    {use_alternate, mem_access, block_move, stack_op} = 6'h01;
    for (int i = 0; i < 6; i++)
    begin
      pair_select_field = (i == 5) ? 3'h0 : 3'(i);
      alt_pair_set = (i == 5);
      tick();
      check("pair value", pair_value_ff, pv[i]);
    end
    rst_n = 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("pc rereset", pc_ff, 16'h0000);
    check("sp rereset", sp_ff, 16'h0000);
    give_verdict();
  end
endmodule // testbench
